/* hdl/scm_pkg.sv */
// package: register map, field layout and constants of the clock mode selector
package scm_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] CONFIG_OFFSET  = 8'h00;
   localparam logic [7:0] GLOBAL_OFFSET  = 8'h04;
   localparam logic [7:0] DIV_LOW_OFFSET = 8'h08;
   localparam logic [7:0] DIV_HIGH_OFFSET = 8'h0C;
   localparam logic [7:0] STATUS_OFFSET  = 8'h10;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CM_LSB     = 0;
   localparam int CM_MSB     = 2;
   localparam int SSEL_BIT   = 3;
   localparam int TOE_BIT    = 4;
   localparam int BCR_BIT    = 5;
   localparam int XTRANS_BIT = 6;
   localparam int OSCILLATOR_POWER_DOWN_BIT  = 0;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [6:0]  CONFIG_RESET = 7'h00;
   localparam logic        OSCILLATOR_POWER_DOWN_RESET  = 1'h1;
   localparam logic [11:0] DIV_RESET    = 12'h000;
   // ----------------------------------------
   // counts
   // ----------------------------------------
   localparam logic [3:0] DIV16_LAST  = 4'hF;
   localparam logic [3:0] SAMPLE_A    = 4'h7;
   localparam logic [3:0] SAMPLE_B    = 4'h8;
   localparam logic [3:0] SAMPLE_LAST = 4'h9;
   localparam logic [2:0] BYTE_REST   = 3'h7;
   // ----------------------------------------
   // synchroniser lanes
   // ----------------------------------------
   localparam int IN_RX_CLOCK_PIN  = 0;
   localparam int IN_TX_CLOCK_PIN  = 1;
   localparam int IN_XTAL   = 2;
   localparam int IN_CD     = 3;
   localparam int IN_RXGATE = 4;
   localparam int IN_TXGATE = 5;
   localparam int IN_FSC    = 6;
   localparam int IN_TXOCT  = 7;
   localparam int IN_RXOCT  = 8;
   localparam int IN_RXDATA = 9;
   localparam int NUM_IN    = 10;
   // ----------------------------------------
   // bus answers and mode codes
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {MODE_0, MODE_1, MODE_2, MODE_3,
                             MODE_4, MODE_5, MODE_6, MODE_7} scm_mode_type;
endpackage : scm_pkg

/* hdl/scm_clock_select.sv */
// module: per-channel clock source and strobe selection with AXI4-Lite registers
// Operation
// - mode field plus source-select bit choose one of fourteen clock modes
// - mode 0: receive from rx pin; transmit from tx pin or crystal-fed generator
// - mode 0b with output enable drives generated transmit clock on tx pin
// - mode 1: rx pin clocks both; carrier detect and tx pin are bit strobes
// - extended transparent mode 1: one strobe permits a whole byte
// - mode 2: generator from rx pin feeds loop at 16x; loop clocks receiver
// - mode 2 transmit: tx pin in 2a, generator/16 in 2b, may drive out
// - mode 3: generator from rx pin; 3a loop clocks both, 3b generator both
// - mode 4: separate pin clocks; gate inputs enable each direction per bit
// - mode 5: slot strobes internal, frame or octet sync inputs synchronise
// - output enable: tx pin shows transmit clock, or slot control in mode 5a
// - mode 6b: transmit is generator/16, generator fed by crystal oscillator
// - loop receive modes: receive clock is loop input divided by 16
// - software should clear oscillator power-down in modes 0b, 6 and 7
// - one oscillator serves channels; crystal pin may take an external clock
// - asynchronous rate bit divides receive clock by 16 in 0a, 0b, 1, 3b, 7b; transmit clock only in 1, 3b, 7b
// - rate bit set: three samples per bit, majority decides
// - rate bit has no effect in modes 2, 3a, 4, 5, 6, 7a
// - loop always sourced from own generator, divider from two registers
`timescale 1ns/100ps
`default_nettype none
module scm_clock_select (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [7:0]        awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [7:0]        araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              rxClockPin,
   input  wire logic              txClockPinIn,
   output logic                   txClockPinOut,
   output logic                   txClockPinOe,
   input  wire logic              crystalInputPin,
   input  wire logic              carrierDetectPin,
   input  wire logic              rxClockGate,
   input  wire logic              txClockGate,
   input  wire logic              frameSyncInput,
   input  wire logic              txOctetSync,
   input  wire logic              rxOctetSync,
   input  wire logic              rxSerialData,
   input  wire logic              rxSlotStrobe,
   input  wire logic              txSlotStrobe,
   output logic                   recTick,
   output logic                   recEnable,
   output logic                   trmTick,
   output logic                   trmEnable,
   output logic                   rxBit,
   output logic                   rxBitValid,
   output logic                   rxSyncPulse,
   output logic                   txSyncPulse,
   output logic                   oscillatorPowerDown
);
   import scm_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [NUM_IN-1:0] sync1;
      logic [NUM_IN-1:0] sync2;
      logic [NUM_IN-1:0] prev;
      logic [6:0]        cfg;
      logic              oscillator_power_down;
      logic [11:0]       div;
      logic [11:0]       brgCount;
      logic              brgTick;
      logic [3:0]        div16Count;
      logic              div16Tick;
      logic [3:0]        recBcrCount;
      logic [3:0]        trmBcrCount;
      logic [1:0]        votes;
      logic              recTick;
      logic              trmTick;
      logic              recEn;
      logic              trmEn;
      logic [2:0]        recLeft;
      logic [2:0]        trmLeft;
      logic              rxBit;
      logic              rxBitValid;
      logic              txLevel;
      logic              txOut;
      logic              txOe;
      logic              rxSync;
      logic              txSync;
      logic              oscWarn;
      logic              awready;
      logic              wready;
      logic              haveAw;
      logic              haveW;
      logic [7:0]        awAddr;
      logic [7:0]        wData;
      logic              wLane0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } scm_state_type;

   localparam scm_state_type RESET_STATE = '{cfg: CONFIG_RESET, oscillator_power_down: OSCILLATOR_POWER_DOWN_RESET,
                                             div: DIV_RESET, default: '0};

   scm_state_type s_reg;
   scm_state_type s_next;

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   scm_mode_type      mode;
   logic              ssel, tx_clock_output_enable, bit_clock_rate_bit, xtrans;
   logic [NUM_IN-1:0] rise;
   logic              rxE, txE, xE, rxd, majNow, tsMode, xByte;
   logic              brgSrc, recSrc, trmSrc, recBcrOn, trmBcrOn;
   logic              hasOut, needOsc, recGate, trmGate;

   // mode field and source select taken together
   assign mode   = scm_mode_type'(s_reg.cfg[CM_MSB:CM_LSB]);
   assign ssel   = s_reg.cfg[SSEL_BIT];
   assign tx_clock_output_enable    = s_reg.cfg[TOE_BIT];
   assign bit_clock_rate_bit    = s_reg.cfg[BCR_BIT];
   assign xtrans = s_reg.cfg[XTRANS_BIT];
   // edges only from the second and third flops, never the first
   assign rise   = s_reg.sync2 & ~s_reg.prev;
   assign rxE    = rise[IN_RX_CLOCK_PIN];
   assign txE    = rise[IN_TX_CLOCK_PIN];
   assign xE     = rise[IN_XTAL];
   assign rxd    = s_reg.sync2[IN_RXDATA];
   assign majNow = (s_reg.votes[0] & s_reg.votes[1]) | (s_reg.votes[0] & rxd)
                 | (s_reg.votes[1] & rxd);
   assign tsMode = (mode == MODE_5) && !ssel;
   assign xByte  = (mode == MODE_1) && xtrans;
   // crystal pin feeds the generator whether oscillator or external clock
   assign needOsc = ((mode == MODE_0) && ssel) || (mode == MODE_6) || (mode == MODE_7);

   // source of each tick per mode
   always_comb begin
      brgSrc = 1'b0;
      recSrc = 1'b0;
      trmSrc = 1'b0;
      hasOut = 1'b0;
      case (mode)
         MODE_0: begin
            brgSrc = xE;
            recSrc = rxE;
            trmSrc = ssel ? s_reg.brgTick : txE;
            hasOut = ssel;
         end
         MODE_1: begin
            recSrc = rxE;
            trmSrc = rxE;
         end
         MODE_2, MODE_6: begin
            brgSrc = (mode == MODE_2) ? rxE : xE;
            recSrc = s_reg.div16Tick;
            trmSrc = ssel ? s_reg.div16Tick : txE;
            hasOut = ssel;
         end
         MODE_3, MODE_7: begin
            brgSrc = (mode == MODE_3) ? rxE : xE;
            recSrc = ssel ? s_reg.brgTick : s_reg.div16Tick;
            trmSrc = ssel ? s_reg.brgTick : s_reg.div16Tick;
            hasOut = 1'b1;
         end
         MODE_4: begin
            recSrc = rxE;
            trmSrc = txE;
         end
         MODE_5: begin
            recSrc = rxE;
            trmSrc = ssel ? txE : rxE;
            hasOut = !ssel;
         end
         default: begin
            brgSrc = 1'b0;
         end
      endcase
   end

   // divide-by-16 only where the rate bit applies
   assign recBcrOn = bit_clock_rate_bit && ((mode == MODE_0) || (mode == MODE_1)
                   || (((mode == MODE_3) || (mode == MODE_7)) && ssel));
   assign trmBcrOn = bit_clock_rate_bit && ((mode == MODE_1)
                   || (((mode == MODE_3) || (mode == MODE_7)) && ssel));

   // per-bit permission: strobes, gates, or slot strobes
   assign recGate = (mode == MODE_1) ? s_reg.sync2[IN_CD]
                  : (mode == MODE_4) ? s_reg.sync2[IN_RXGATE]
                  : (mode == MODE_5) ? rxSlotStrobe : 1'b1;
   assign trmGate = (mode == MODE_1) ? s_reg.sync2[IN_TX_CLOCK_PIN]
                  : (mode == MODE_4) ? s_reg.sync2[IN_TXGATE]
                  : (mode == MODE_5) ? txSlotStrobe : 1'b1;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      // two-flop synchronisers, third flop for edges
      s_next.sync1 = {rxSerialData, rxOctetSync, txOctetSync, frameSyncInput, txClockGate,
                      rxClockGate, carrierDetectPin, crystalInputPin, txClockPinIn,
                      rxClockPin};
      s_next.sync2 = s_reg.sync1;
      s_next.prev  = s_reg.sync2;

      // generator counts source edges, divider from two registers
      s_next.brgTick   = 1'b0;
      s_next.div16Tick = 1'b0;
      if (brgSrc) begin
         if (s_reg.brgCount >= s_reg.div) begin
            s_next.brgCount = 12'h000;
            s_next.brgTick  = 1'b1;
         end else begin
            s_next.brgCount = s_reg.brgCount + 12'h001;
         end
      end
      // loop and transmit divide the generator by 16
      if (s_reg.brgTick) begin
         s_next.div16Count = s_reg.div16Count + 4'h1;
         s_next.div16Tick  = (s_reg.div16Count == DIV16_LAST);
      end

      // receive tick, with 3-sample majority when divided
      s_next.recTick    = 1'b0;
      s_next.rxBitValid = 1'b0;
      if (!recBcrOn) begin
         s_next.recBcrCount = 4'h0;
         if (recSrc) begin
            s_next.recTick    = 1'b1;
            s_next.rxBit      = rxd;
            s_next.rxBitValid = 1'b1;
         end
      end else if (recSrc) begin
         s_next.recBcrCount = s_reg.recBcrCount + 4'h1;
         s_next.recTick     = (s_reg.recBcrCount == DIV16_LAST);
         if (s_reg.recBcrCount == SAMPLE_A) begin
            s_next.votes[0] = rxd;
         end
         if (s_reg.recBcrCount == SAMPLE_B) begin
            s_next.votes[1] = rxd;
         end
         if (s_reg.recBcrCount == SAMPLE_LAST) begin
            s_next.rxBit      = majNow;
            s_next.rxBitValid = 1'b1;
         end
      end

      // transmit tick
      s_next.trmTick = 1'b0;
      if (!trmBcrOn) begin
         s_next.trmBcrCount = 4'h0;
         s_next.trmTick     = trmSrc;
      end else if (trmSrc) begin
         s_next.trmBcrCount = s_reg.trmBcrCount + 4'h1;
         s_next.trmTick     = (s_reg.trmBcrCount == DIV16_LAST);
      end

      // enables latched per bit; byte grant in transparent mode 1
      if (s_next.recTick) begin
         if (xByte && (s_reg.recLeft != 3'h0)) begin
            s_next.recEn   = 1'b1;
            s_next.recLeft = s_reg.recLeft - 3'h1;
         end else begin
            s_next.recEn   = recGate;
            s_next.recLeft = (xByte && recGate) ? BYTE_REST : 3'h0;
         end
      end
      if (s_next.trmTick) begin
         if (xByte && (s_reg.trmLeft != 3'h0)) begin
            s_next.trmEn   = 1'b1;
            s_next.trmLeft = s_reg.trmLeft - 3'h1;
         end else begin
            s_next.trmEn   = trmGate;
            s_next.trmLeft = (xByte && trmGate) ? BYTE_REST : 3'h0;
         end
      end

      // sync inputs in mode 5: frame sync in 5a, octet syncs in 5b
      s_next.txSync = (mode == MODE_5) && (ssel ? rise[IN_TXOCT] : rise[IN_FSC]);
      s_next.rxSync = (mode == MODE_5) && (ssel ? rise[IN_RXOCT] : rise[IN_FSC]);

      // tx pin: effective transmit clock, or active-low slot window
      if (s_next.trmTick) begin
         s_next.txLevel = !s_reg.txLevel;
      end
      s_next.txOut = tsMode ? !txSlotStrobe : s_next.txLevel;
      s_next.txOe  = tx_clock_output_enable && hasOut;

      // flag for software: oscillator still powered down
      s_next.oscWarn = s_reg.oscillator_power_down && needOsc;

      // write channel: address and data in either order
      if (s_reg.bvalid && bready) begin
         s_next.bvalid = 1'b0;
      end
      if (awvalid && s_reg.awready) begin
         s_next.haveAw = 1'b1;
         s_next.awAddr = awaddr;
      end
      if (wvalid && s_reg.wready) begin
         s_next.haveW  = 1'b1;
         s_next.wData  = wdata[7:0];
         s_next.wLane0 = wstrb[0];
      end
      if (s_reg.haveAw && s_reg.haveW && !s_reg.bvalid) begin
         s_next.haveAw = 1'b0;
         s_next.haveW  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = RESP_OKAY;
         case (s_reg.awAddr)
            CONFIG_OFFSET: begin
               if (s_reg.wLane0) s_next.cfg = s_reg.wData[6:0];
            end
            GLOBAL_OFFSET: begin
               if (s_reg.wLane0) s_next.oscillator_power_down = s_reg.wData[OSCILLATOR_POWER_DOWN_BIT];
            end
            DIV_LOW_OFFSET: begin
               if (s_reg.wLane0) s_next.div[7:0] = s_reg.wData;
            end
            DIV_HIGH_OFFSET: begin
               if (s_reg.wLane0) s_next.div[11:8] = s_reg.wData[3:0];
            end
            STATUS_OFFSET: begin
               s_next.bresp = RESP_OKAY;
            end
            default: begin
               s_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      s_next.awready = !s_next.haveAw && !s_next.bvalid;
      s_next.wready  = !s_next.haveW && !s_next.bvalid;

      // read channel: one outstanding read
      if (s_reg.rvalid && rready) begin
         s_next.rvalid = 1'b0;
      end
      if (arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = RESP_OKAY;
         s_next.rdata  = 32'h0000_0000;
         case (araddr)
            CONFIG_OFFSET:   s_next.rdata[6:0]  = s_reg.cfg;
            GLOBAL_OFFSET:   s_next.rdata[0]    = s_reg.oscillator_power_down;
            DIV_LOW_OFFSET:  s_next.rdata[7:0]  = s_reg.div[7:0];
            DIV_HIGH_OFFSET: s_next.rdata[3:0]  = s_reg.div[11:8];
            STATUS_OFFSET:   s_next.rdata[3:0]  = {s_reg.txOe, s_reg.trmEn,
                                                   s_reg.recEn, s_reg.oscWarn};
            default:         s_next.rresp       = RESP_SLVERR;
         endcase
      end
      s_next.arready = !s_next.rvalid;
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= RESET_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign awready             = s_reg.awready;
   assign wready              = s_reg.wready;
   assign bresp               = s_reg.bresp;
   assign bvalid              = s_reg.bvalid;
   assign arready             = s_reg.arready;
   assign rdata               = s_reg.rdata;
   assign rresp               = s_reg.rresp;
   assign rvalid              = s_reg.rvalid;
   assign txClockPinOut       = s_reg.txOut;
   assign txClockPinOe        = s_reg.txOe;
   assign recTick             = s_reg.recTick;
   assign recEnable           = s_reg.recEn;
   assign trmTick             = s_reg.trmTick;
   assign trmEnable           = s_reg.trmEn;
   assign rxBit               = s_reg.rxBit;
   assign rxBitValid          = s_reg.rxBitValid;
   assign rxSyncPulse         = s_reg.rxSync;
   assign txSyncPulse         = s_reg.txSync;
   assign oscillatorPowerDown = s_reg.oscillator_power_down;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_tx_pin_enable: assert property (txClockPinOe |-> $past(tx_clock_output_enable) && $past(hasOut))
      else $error("tx pin driven without output enable");
   a_slot_control: assert property ($past(tsMode) |-> txClockPinOut == !$past(txSlotStrobe))
      else $error("slot window not shown on tx pin");
   a_loop_div: assert property (s_reg.div16Tick |-> $past(s_reg.brgTick)
                                && ($past(s_reg.div16Count) == DIV16_LAST))
      else $error("loop output not generator over 16");
   a_rx_pin_direct: assert property ((mode == MODE_0 && !recBcrOn && rxE) |=> recTick)
      else $error("rx pin edge gave no receive tick");
   a_bcr_slow: assert property ((recBcrOn && recSrc && s_reg.recBcrCount != DIV16_LAST)
                                |=> !recTick)
      else $error("divided receive tick too early");
   a_bcr_ignored: assert property ((recSrc && !recBcrOn) |=> recTick ##1 !recTick)
      else $error("rate bit changed an undivided mode");
   a_majority_vote: assert property ((recBcrOn && recSrc && s_reg.recBcrCount == SAMPLE_LAST)
                                     |=> rxBitValid && (rxBit == $past(majNow)))
      else $error("bit not decided by majority");
   a_byte_window: assert property ((xByte && s_reg.recLeft != 3'h0 && s_next.recTick)
                                   |=> recEnable)
      else $error("byte grant lost within byte");
   a_gate_mode4: assert property ((mode == MODE_4 && s_next.recTick)
                                  |=> recEnable == $past(recGate))
      else $error("receive gate not applied");
   a_strobe_mode1: assert property ((mode == MODE_1 && !xtrans && s_next.trmTick)
                                    |=> trmEnable == $past(trmGate))
      else $error("transmit strobe not applied");
   a_crystal_tx: assert property ((mode == MODE_6 && ssel && !trmBcrOn && s_reg.div16Tick)
                                  |=> trmTick)
      else $error("mode 6b transmit not generator over 16");
   a_osc_advice: assert property ((s_reg.oscillator_power_down && needOsc) |=> s_reg.oscWarn)
      else $error("oscillator warning missing");
endmodule : scm_clock_select
`default_nettype wire

/* verification/scm_line_partner.sv */
// partner: far-side serial clock, strobe and data sources
`timescale 1ns/100ps
`default_nettype none
module scm_line_partner (
   input  wire logic clk,
   output logic      rxClockPin,
   output logic      txClockPinIn,
   output logic      crystalInputPin,
   output logic      carrierDetectPin,
   output logic      rxClockGate,
   output logic      txClockGate,
   output logic      rxSerialData,
   output logic      frameSyncInput,
   output logic      txOctetSync,
   output logic      rxOctetSync
);
   // carrier detect and both gates held active; the tx pin strobe is high only during tx lane edges
   initial begin
      {crystalInputPin, txClockPinIn, rxClockPin} = 3'h0;
      carrierDetectPin = 1'h1;
      {rxClockGate, txClockGate} = 2'h3;
      rxSerialData = 1'h0;
      {rxOctetSync, txOctetSync, frameSyncInput} = 3'h0;
   end
   // one clock per lane, slow enough for the sampler; idle low between bursts
   task automatic send_edges(input logic [2:0] lanes, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge clk);
         {crystalInputPin, txClockPinIn, rxClockPin} <= lanes;
         // frame sync rides the rx lane, octet syncs the tx lane
         {rxOctetSync, txOctetSync, frameSyncInput} <= {lanes[1], lanes[1], lanes[0]};
         rxSerialData <= ~rxSerialData;
         repeat (4) @(posedge clk);
         {crystalInputPin, txClockPinIn, rxClockPin} <= 3'h0;
         {rxOctetSync, txOctetSync, frameSyncInput} <= 3'h0;
      end
   endtask : send_edges
endmodule : scm_line_partner
`default_nettype wire

/* verification/scm_clock_select_bench.sv */
// bench: register access and clock mode scenarios for the clock selector
`timescale 1ns/100ps
`default_nettype none
module scm_clock_select_bench;
   import scm_pkg::*;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, txClockPinOut, txClockPinOe, recTick, recEnable, trmTick;
   logic trmEnable, rxBit, rxBitValid, rxSyncPulse, txSyncPulse, oscillatorPowerDown;
   logic rxClockPin, txClockPinIn, crystalInputPin, carrierDetectPin;
   logic rxClockGate, txClockGate, rxSerialData;
   logic frameSyncInput, txOctetSync, rxOctetSync, slotOn;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   int          miscompares, samplesChecked, recCount, trmCount;
   int          rxSynCount, txSynCount, bitCount;
   // mode table: config byte, pin lanes {crystal,tx,rx}, edges, expected ticks,
   // and {tx pin level, trmEnable, recEnable} at the end of the burst
   logic [7:0] cfgTab [11] = '{8'h00, 8'h18, 8'h20, 8'h2A, 8'h0B, 8'h01, 8'h04, 8'h0E,
                               8'h15, 8'h0D, 8'h41};
   logic [2:0] laneTab [11] = '{3'h3, 3'h5, 3'h3, 3'h1, 3'h1, 3'h1, 3'h3, 3'h5, 3'h1, 3'h2, 3'h1};
   int edgeTab [11] = '{4, 4, 32, 32, 4, 4, 4, 32, 4, 4, 4};
   int recTab [11] = '{4, 4, 2, 2, 4, 4, 4, 2, 4, 0, 4};
   int trmTab [11] = '{4, 4, 32, 2, 4, 4, 4, 2, 4, 4, 4};
   logic [2:0] outTab [11] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h1, 3'h3, 3'h3, 3'h4, 3'h2, 3'h1};
   // slot strobes stand in for the time-slot logic, which is outside this block
   scm_clock_select dut_u (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .rxClockPin, .txClockPinIn, .txClockPinOut, .txClockPinOe,
      .crystalInputPin, .carrierDetectPin, .rxClockGate, .txClockGate,
      .frameSyncInput, .txOctetSync, .rxOctetSync, .rxSerialData,
      .rxSlotStrobe(slotOn), .txSlotStrobe(slotOn), .recTick, .recEnable, .trmTick, .trmEnable,
      .rxBit, .rxBitValid, .rxSyncPulse, .txSyncPulse, .oscillatorPowerDown);
   scm_line_partner line_u (.clk, .rxClockPin, .txClockPinIn, .crystalInputPin,
      .carrierDetectPin, .rxClockGate, .txClockGate, .rxSerialData, .frameSyncInput,
      .txOctetSync, .rxOctetSync);
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // pulses stand one cycle, so count them at every edge; reset clears the counts
   always @(posedge clk) begin
      if (rst_n !== 1'b1) begin
         {recCount, trmCount, rxSynCount, txSynCount, bitCount} = '0;
      end else begin
         if (recTick === 1'b1) recCount++;
         if (trmTick === 1'b1) trmCount++;
         if (rxSyncPulse === 1'b1) rxSynCount++;
         if (txSyncPulse === 1'b1) txSynCount++;
         if (rxBitValid === 1'b1) bitCount++;
      end
   end
   task automatic pulse_reset();
      rst_n <= 1'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
   endtask : pulse_reset
   // address and data offered together, each released once taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'h0;
         if (wready === 1'b1) wvalid <= 1'h0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'h0;
      @(posedge clk);
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'h0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      @(posedge clk);
   endtask : axi_read
   task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
      samplesChecked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask : check
   task automatic tally_and_finish();
      if (miscompares == 0 && samplesChecked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // watchdog at 10000 cycles, well beyond the roughly 1300 cycles the sequence needs
   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
      slotOn = 1'h0;
      pulse_reset();
      axi_read(CONFIG_OFFSET, rd, resp);
      check("config_reset", 32'h0, rd);
      axi_read(GLOBAL_OFFSET, rd, resp);
      check("osc_pd_reset", 32'h1, rd);
      axi_read(8'h20, rd, resp);
      check("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      axi_write(GLOBAL_OFFSET, 32'h0, resp);
      check("osc_pd_pin", 32'h0, {31'h0, oscillatorPowerDown});
      axi_write(DIV_LOW_OFFSET, 32'h5A, resp);
      axi_read(DIV_LOW_OFFSET, rd, resp);
      check("div_low", 32'h5A, rd);
      axi_write(DIV_HIGH_OFFSET, 32'hFF, resp);
      axi_read(DIV_HIGH_OFFSET, rd, resp);
      check("div_high", 32'hF, rd);
      // each mode from a fresh reset so no divider carries residue
      for (int k = 0; k < 11; k++) begin
         pulse_reset();
         axi_write(CONFIG_OFFSET, {24'h0, cfgTab[k]}, resp);
         slotOn <= cfgTab[k][3];
         line_u.send_edges(laneTab[k], edgeTab[k]);
         repeat (8) @(posedge clk);
         check("rec_ticks", recTab[k], recCount);
         check("trm_ticks", trmTab[k], trmCount);
         check("tx_pin_oe", {31'h0, cfgTab[k][4]}, {31'h0, txClockPinOe});
         check("pin_enables", {29'h0, outTab[k]}, {29'h0, txClockPinOut, trmEnable, recEnable});
         check("rx_sync", (cfgTab[k][2:0] == 3'h5) ? edgeTab[k] : 0, rxSynCount);
         check("tx_sync", (cfgTab[k][2:0] == 3'h5) ? edgeTab[k] : 0, txSynCount);
         check("bit_valid", recTab[k], bitCount);
      end
      tally_and_finish();
   end
endmodule : scm_clock_select_bench
`default_nettype wire
